// ---- spar_abs_lane.sv ----
`timescale 1ns/1ps
module spar_abs_lane #(
  parameter int unsigned W = 8
) (
  spar_vec_if.lane port
);
  localparam int unsigned N = 64 / W;
  localparam logic [W-1:0] MOST_NEG = {1'b1, {(W-1){1'b0}}};
  localparam logic [W-1:0] MOST_POS = {1'b0, {(W-1){1'b1}}};

  // magnitude per element, -1.0 clamps to the largest positive value
  for (genvar i = 0; i < N; i++) begin : g_el
    wire [W-1:0] el  = port.vec[i*W +: W];
    wire [W-1:0] neg = W'(~el + 1'b1);
    assign port.mag[i*W +: W] = (el == MOST_NEG) ? MOST_POS : (el[W-1] ? neg : el);
  end
endmodule

// ---- spar_alu.sv ----
`timescale 1ns/1ps
// What this block does
// - circular index minus decrement, underflow loads restart
// - word sum of four right bytes
// - doubleword sum of eight bytes, zero-extended
// - 32-bit results copy sign into upper half
// - byte abs, -1.0 becomes max Q7
// - halfword abs, -1.0 becomes max Q15
// - word abs, -1.0 becomes max Q31
// - integer narrow drops upper eight bits
// - first source fills left result elements
// - Q15 to Q7 keeps upper byte
// - shift right, optional round, keep low halfword
// - Q31 to Q15 upper half, optional round-saturate
// - Q63 to Q31 keeps upper word
// - Q15 to unsigned byte saturates then truncates
// - single Q15 widened to sign-extended Q31
// - two Q15 elements widened to Q31
// - Q31 widened to Q63 with zeros
// - unsigned byte to Q15, zero sign
// - unsigned byte to halfword, eight zeros below
// - only the general register is written
module spar_alu
  import spar_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        valid_in,
  input  wire spar_op_t    op_in,
  input  wire spar_sel_t   select_in,
  input  wire logic [63:0] source_reg_a_in,
  input  wire logic [63:0] source_reg_b_in,
  input  wire logic [4:0]  shift_amount_in,
  input  wire logic        round_in,
  output logic [63:0]      result_out,
  output logic             result_valid_out,
  output logic             gpr_write_out,
  output logic             acc_write_out,
  output logic             status_write_out
);

  // sign-extend a word result into the full register
  function automatic logic [63:0] ext32(input logic [31:0] w);
    return {{WORD_W{w[WORD_W-1]}}, w};
  endfunction

  // index of the element picked for output k of n
  function automatic int unsigned pick(input spar_sel_t s, input int unsigned n,
                                       input int unsigned k);
    case (s)
      SEL_LEFT:     return n + k;
      SEL_RIGHT:    return k;
      SEL_LEFT_ALT: return 2 * k + 1;
      default:      return 2 * k;
    endcase
  endfunction

  // arithmetic shift with optional rounding at the top discarded bit
  function automatic logic [15:0] sra_nrw(input logic [31:0] x, input logic [4:0] sa,
                                          input logic rnd);
    logic signed [32:0] wide;
    logic signed [32:0] t;
    wide = {x[WORD_W-1], x};
    t = wide >>> sa;
    if (rnd && (sa != '0)) begin
      t = (wide >>> (sa - 5'd1)) + 33'sd1;
      return t[HALF_W:1];
    end
    return t[HALF_W-1:0];
  endfunction

  // Q31 to Q15 with rounding and saturation
  function automatic logic [15:0] q31_rs(input logic [31:0] x);
    logic [31:0] t;
    t = x + Q31_RND_ADD;
    if ($signed(x) >= $signed(Q31_RND_LIMIT)) return Q15_MAX;
    return t[WORD_W-1:HALF_W];
  endfunction

  // Q15 to unsigned byte: negative clamps to zero, large to max
  function automatic logic [7:0] ub_sat(input logic [15:0] h);
    if (h[HALF_W-1]) return UBYTE_ZERO;
    if (h > Q15_USAT_LIMIT) return UBYTE_MAX;
    return h[HALF_W-2:BYTE_W-1];
  endfunction

  // saturating abs lanes for each element width
  spar_vec_if abs_b_if ();
  spar_vec_if abs_h_if ();
  spar_vec_if abs_w_if ();
  assign abs_b_if.vec = source_reg_b_in;
  assign abs_h_if.vec = source_reg_b_in;
  assign abs_w_if.vec = source_reg_b_in;
  spar_abs_lane #(.W(BYTE_W)) u_abs_b (.port(abs_b_if.lane));
  spar_abs_lane #(.W(HALF_W)) u_abs_h (.port(abs_h_if.lane));
  spar_abs_lane #(.W(WORD_W)) u_abs_w (.port(abs_w_if.lane));

  // circular index decrement
  wire [31:0] circ_index   = source_reg_a_in[WORD_W-1:0];
  wire [31:0] circ_dec     = 32'(source_reg_b_in[DEC_LSB +: BYTE_W]);
  wire [31:0] circ_restart = 32'(source_reg_b_in[RESTART_LSB +: RESTART_W]);
  wire        circ_under   = circ_index < circ_dec;
  wire [31:0] circ_next    = circ_under ? circ_restart : (circ_index - circ_dec);

  // byte sums
  logic [10:0] sum_w;
  logic [10:0] sum_d;
  always_comb begin
    sum_w = '0;
    sum_d = '0;
    for (int i = 0; i < 8; i++) begin
      sum_d = sum_d + 11'(source_reg_a_in[i*BYTE_W +: BYTE_W]);
      if (i < 4) sum_w = sum_w + 11'(source_reg_a_in[i*BYTE_W +: BYTE_W]);
    end
  end

  // narrowing results, first source always in the left elements
  logic [31:0] nrw_int_qb, nrw_frac_qb, nrw_ub_qb, nrw_sra_ph, nrw_q31_ph, nrw_rs_ph;
  logic [63:0] nrw_int_ob, nrw_frac_ob, nrw_ub_ob, nrw_sra_qh, nrw_q31_qh, nrw_rs_qh;
  always_comb begin
    logic [15:0] h;
    logic [31:0] w;
    h = '0;
    w = '0;
    for (int k = 0; k < 2; k++) begin
      h = source_reg_a_in[k*HALF_W +: HALF_W];
      nrw_int_qb[(k+2)*BYTE_W +: BYTE_W]  = h[BYTE_W-1:0];
      nrw_frac_qb[(k+2)*BYTE_W +: BYTE_W] = h[HALF_W-1:BYTE_W];
      nrw_ub_qb[(k+2)*BYTE_W +: BYTE_W]   = ub_sat(h);
      h = source_reg_b_in[k*HALF_W +: HALF_W];
      nrw_int_qb[k*BYTE_W +: BYTE_W]  = h[BYTE_W-1:0];
      nrw_frac_qb[k*BYTE_W +: BYTE_W] = h[HALF_W-1:BYTE_W];
      nrw_ub_qb[k*BYTE_W +: BYTE_W]   = ub_sat(h);
    end
    for (int k = 0; k < 4; k++) begin
      h = source_reg_a_in[k*HALF_W +: HALF_W];
      nrw_int_ob[(k+4)*BYTE_W +: BYTE_W]  = h[BYTE_W-1:0];
      nrw_frac_ob[(k+4)*BYTE_W +: BYTE_W] = h[HALF_W-1:BYTE_W];
      nrw_ub_ob[(k+4)*BYTE_W +: BYTE_W]   = ub_sat(h);
      h = source_reg_b_in[k*HALF_W +: HALF_W];
      nrw_int_ob[k*BYTE_W +: BYTE_W]  = h[BYTE_W-1:0];
      nrw_frac_ob[k*BYTE_W +: BYTE_W] = h[HALF_W-1:BYTE_W];
      nrw_ub_ob[k*BYTE_W +: BYTE_W]   = ub_sat(h);
    end
    // word sources: a gives the left halfword(s)
    w = source_reg_a_in[WORD_W-1:0];
    nrw_sra_ph[WORD_W-1:HALF_W] = sra_nrw(w, shift_amount_in, round_in);
    nrw_q31_ph[WORD_W-1:HALF_W] = w[WORD_W-1:HALF_W];
    nrw_rs_ph[WORD_W-1:HALF_W]  = q31_rs(w);
    w = source_reg_b_in[WORD_W-1:0];
    nrw_sra_ph[HALF_W-1:0] = sra_nrw(w, shift_amount_in, round_in);
    nrw_q31_ph[HALF_W-1:0] = w[WORD_W-1:HALF_W];
    nrw_rs_ph[HALF_W-1:0]  = q31_rs(w);
    for (int k = 0; k < 2; k++) begin
      w = source_reg_a_in[k*WORD_W +: WORD_W];
      nrw_sra_qh[(k+2)*HALF_W +: HALF_W] = sra_nrw(w, shift_amount_in, round_in);
      nrw_q31_qh[(k+2)*HALF_W +: HALF_W] = w[WORD_W-1:HALF_W];
      nrw_rs_qh[(k+2)*HALF_W +: HALF_W]  = q31_rs(w);
      w = source_reg_b_in[k*WORD_W +: WORD_W];
      nrw_sra_qh[k*HALF_W +: HALF_W] = sra_nrw(w, shift_amount_in, round_in);
      nrw_q31_qh[k*HALF_W +: HALF_W] = w[WORD_W-1:HALF_W];
      nrw_rs_qh[k*HALF_W +: HALF_W]  = q31_rs(w);
    end
  end

  // Q63 to Q31, upper words of each source
  wire [63:0] nrw_q63 = {source_reg_a_in[DWORD_W-1:WORD_W],
                         source_reg_b_in[DWORD_W-1:WORD_W]};

  // widening results from source_reg_b, elements chosen by the selector
  logic [31:0] wid_q15_w, wid_ubq_ph, wid_ubh_ph;
  logic [63:0] wid_q15_pw, wid_q31_l, wid_ubq_qh, wid_ubh_qh;
  always_comb begin
    logic [15:0] h;
    logic [7:0]  b;
    b = '0;
    h = source_reg_b_in[pick(select_in, 1, 0)*HALF_W +: HALF_W];
    wid_q15_w = {h, {HALF_W{1'b0}}};
    wid_q31_l = {source_reg_b_in[pick(select_in, 1, 0)*WORD_W +: WORD_W],
                 {WORD_W{1'b0}}};
    for (int k = 0; k < 2; k++) begin
      h = source_reg_b_in[pick(select_in, 2, k)*HALF_W +: HALF_W];
      wid_q15_pw[k*WORD_W +: WORD_W] = {h, {HALF_W{1'b0}}};
      b = source_reg_b_in[pick(select_in, 2, k)*BYTE_W +: BYTE_W];
      wid_ubq_ph[k*HALF_W +: HALF_W] = {1'b0, b, {(BYTE_W-1){1'b0}}};
      wid_ubh_ph[k*HALF_W +: HALF_W] = {b, {BYTE_W{1'b0}}};
    end
    for (int k = 0; k < 4; k++) begin
      b = source_reg_b_in[pick(select_in, 4, k)*BYTE_W +: BYTE_W];
      wid_ubq_qh[k*HALF_W +: HALF_W] = {1'b0, b, {(BYTE_W-1){1'b0}}};
      wid_ubh_qh[k*HALF_W +: HALF_W] = {b, {BYTE_W{1'b0}}};
    end
  end

  // result selection; word-sized results carry their sign upward
  logic [63:0] result_d;
  always_comb begin
    case (op_in)
      OP_CIRC_DEC:    result_d = ext32(circ_next);
      OP_SUM_W:       result_d = ext32(32'(sum_w));
      OP_SUM_D:       result_d = 64'(sum_d);
      OP_ABS_QB:      result_d = ext32(abs_b_if.mag[WORD_W-1:0]);
      OP_ABS_OB:      result_d = abs_b_if.mag;
      OP_ABS_PH:      result_d = ext32(abs_h_if.mag[WORD_W-1:0]);
      OP_ABS_QH:      result_d = abs_h_if.mag;
      OP_ABS_W:       result_d = ext32(abs_w_if.mag[WORD_W-1:0]);
      OP_ABS_PW:      result_d = abs_w_if.mag;
      OP_NRW_INT_QB:  result_d = ext32(nrw_int_qb);
      OP_NRW_INT_OB:  result_d = nrw_int_ob;
      OP_NRW_FRAC_QB: result_d = ext32(nrw_frac_qb);
      OP_NRW_FRAC_OB: result_d = nrw_frac_ob;
      OP_NRW_SRA_PH:  result_d = ext32(nrw_sra_ph);
      OP_NRW_SRA_QH:  result_d = nrw_sra_qh;
      OP_NRW_Q31_PH:  result_d = ext32(nrw_q31_ph);
      OP_NRW_Q31_QH:  result_d = nrw_q31_qh;
      OP_NRW_RS_PH:   result_d = ext32(nrw_rs_ph);
      OP_NRW_RS_QH:   result_d = nrw_rs_qh;
      OP_NRW_Q63:     result_d = nrw_q63;
      OP_NRW_UB_QB:   result_d = ext32(nrw_ub_qb);
      OP_NRW_UB_OB:   result_d = nrw_ub_ob;
      OP_WID_Q15_W:   result_d = ext32(wid_q15_w);
      OP_WID_Q15_PW:  result_d = wid_q15_pw;
      OP_WID_Q31_L:   result_d = wid_q31_l;
      OP_WID_UBQ_PH:  result_d = ext32(wid_ubq_ph);
      OP_WID_UBQ_QH:  result_d = wid_ubq_qh;
      OP_WID_UBH_PH:  result_d = ext32(wid_ubh_ph);
      OP_WID_UBH_QH:  result_d = wid_ubh_qh;
      default:        result_d = RESULT_RST;
    endcase
  end

  // one result stage
  logic [63:0] result_q;
  logic        valid_q;
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      result_q <= RESULT_RST;
      valid_q  <= 1'b0;
    end else begin
      result_q <= valid_in ? result_d : result_q;
      valid_q  <= valid_in;
    end
  end

  // only the general register write is ever raised
  assign result_out       = result_q;
  assign result_valid_out = valid_q;
  assign gpr_write_out    = valid_q;
  assign acc_write_out    = 1'b0;
  assign status_write_out = 1'b0;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  result_latency_a: assert property (valid_in |=> result_valid_out && gpr_write_out)
    else $error("result not written one cycle after issue");
  no_side_write_a: assert property (result_valid_out
      |-> !acc_write_out && !status_write_out)
    else $error("accumulator or status written");
  circ_restart_a: assert property (valid_in && op_in == OP_CIRC_DEC && circ_under
      |=> result_out[31:0] == $past(source_reg_b_in[23:8]))
    else $error("underflow did not load restart value");
  sum_word_a: assert property (valid_in && op_in == OP_SUM_W
      && source_reg_a_in[31:0] == 32'h8080_8080 |=> result_out == 64'h0000_0000_0000_0200)
    else $error("word byte sum wrong");
  sum_dword_a: assert property (valid_in && op_in == OP_SUM_D
      && source_reg_a_in == 64'hffff_ffff_ffff_ffff |=> result_out == 64'h0000_0000_0000_07f8)
    else $error("doubleword byte sum wrong");
  upper_sign_a: assert property (valid_in
      && op_in inside {OP_ABS_PH, OP_NRW_Q31_PH, OP_WID_Q15_W}
      |=> result_out[63:32] == {32{result_out[31]}})
    else $error("upper half not sign copy");
  abs_byte_sat_a: assert property (valid_in && op_in == OP_ABS_OB
      && source_reg_b_in[7:0] == 8'h80 |=> result_out[7:0] == 8'h7f)
    else $error("Q7 -1.0 not saturated");
  abs_half_sat_a: assert property (valid_in && op_in == OP_ABS_QH
      && source_reg_b_in[63:48] == 16'h8000 |=> result_out[63:48] == 16'h7fff)
    else $error("Q15 -1.0 not saturated");
  abs_word_sat_a: assert property (valid_in && op_in == OP_ABS_W
      && source_reg_b_in[31:0] == 32'h8000_0000 |=> result_out == 64'h0000_0000_7fff_ffff)
    else $error("Q31 -1.0 not saturated");
  narrow_order_a: assert property (valid_in && op_in == OP_NRW_INT_QB
      |=> result_out[31:24] == $past(source_reg_a_in[23:16])
          && result_out[7:0] == $past(source_reg_b_in[7:0]))
    else $error("integer narrow placement wrong");
  q63_left_a: assert property (valid_in && op_in == OP_NRW_Q63
      |=> result_out[63:32] == $past(source_reg_a_in[63:32]))
    else $error("Q63 narrow left word wrong");
  ub_negative_a: assert property (valid_in && op_in == OP_NRW_UB_QB
      && source_reg_a_in[31] |=> result_out[31:24] == 8'h00)
    else $error("negative Q15 not clamped to zero");
  widen_q63_a: assert property (valid_in && op_in == OP_WID_Q31_L
      && select_in == SEL_LEFT |=> result_out == {$past(source_reg_b_in[63:32]), 32'h0000_0000})
    else $error("Q31 widen wrong");
  widen_ubq_a: assert property (valid_in && op_in == OP_WID_UBQ_QH
      |=> result_out[63] == 1'b0 && result_out[6:0] == 7'h00)
    else $error("unsigned byte to Q15 wrong");
  frac_narrow_a: assert property (valid_in && op_in == OP_NRW_FRAC_QB
      |=> result_out[31:24] == $past(source_reg_a_in[31:24])
          && result_out[7:0] == $past(source_reg_b_in[15:8]))
    else $error("Q15 to Q7 narrow wrong");
  round_sat_a: assert property (valid_in && op_in == OP_NRW_RS_PH
      && $signed(source_reg_a_in[31:0]) >= $signed(32'h7fff_8000)
      |=> result_out[31:16] == 16'h7fff)
    else $error("rounded narrow not saturated");
  widen_q15_a: assert property (valid_in && op_in == OP_WID_Q15_W
      && select_in == SEL_RIGHT |=> result_out
          == {{32{$past(source_reg_b_in[15])}}, $past(source_reg_b_in[15:0]), 16'h0000})
    else $error("Q15 widen wrong");

endmodule

// ---- spar_alu_tb.sv ----
`timescale 1ns/1ps
// compare two values, count it, and report a mismatch at once
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module spar_alu_tb
  import spar_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        valid, rnd, rv, gw, aw, sw;
  spar_op_t    op;
  spar_sel_t   sel;
  logic [63:0] a, b, result, last_q;
  logic [4:0]  sa;
  logic [63:0] exp_q[$];
  int          err_total = 0;
  int          checks_done = 0;

  // 100 MHz clock
  always #5 clk_in = ~clk_in;

  spar_issue_model spar_issue_model_inst (.clk_in(clk_in), .valid_out(valid), .op_out(op),
    .select_out(sel), .reg_a_out(a), .reg_b_out(b), .shift_out(sa), .round_out(rnd));

  spar_alu spar_alu_inst (.clk_in(clk_in), .rstn_in(rstn_in), .valid_in(valid), .op_in(op),
    .select_in(sel), .source_reg_a_in(a), .source_reg_b_in(b), .shift_amount_in(sa),
    .round_in(rnd), .result_out(result), .result_valid_out(rv), .gpr_write_out(gw),
    .acc_write_out(aw), .status_write_out(sw));

  // saturating magnitude of one w-bit element
  function automatic logic [63:0] sabs(input logic [63:0] e, input int w);
    logic [63:0] m;
    m = 64'h0000_0000_0000_0001 << (w - 1);
    if (e == m) return m - 1;
    return e[w-1] ? ((~e + 1) & ((m << 1) - 1)) : e;
  endfunction

  // one narrowed element from one input element
  function automatic logic [63:0] nar(input spar_op_t o, input logic [63:0] e,
                                      input logic [4:0] s, input logic r);
    logic signed [31:0] x;
    logic [31:0]        t;
    x = $signed(e[31:0]) >>> s;
    if (r && s != 5'h00) x = (($signed(e[31:0]) >>> (s - 5'h01)) + 32'sh0000_0001) >>> 1;
    t = e[31:0] + 32'h0000_8000;
    case (o)
      OP_NRW_INT_QB, OP_NRW_INT_OB: return e[7:0];
      OP_NRW_FRAC_QB, OP_NRW_FRAC_OB: return e[15:8];
      OP_NRW_SRA_PH, OP_NRW_SRA_QH: return x[15:0];
      OP_NRW_Q31_PH, OP_NRW_Q31_QH: return e[31:16];
      OP_NRW_RS_PH, OP_NRW_RS_QH: return ($signed(e[31:0]) >= $signed(32'h7fff_8000)) ?
                                         16'h7fff : t[31:16];
      OP_NRW_Q63: return e[63:32];
      default: return e[15] ? 8'h00 : (e[15:0] > 16'h7f80 ? 8'hff : e[14:7]);
    endcase
  endfunction

  // expected result of one op
  function automatic logic [63:0] ref_res(input spar_op_t o, input spar_sel_t s,
    input logic [63:0] ra, input logic [63:0] rb, input logic [4:0] sh_a, input logic r);
    logic [63:0] res, e, m;
    int          n, w, sh, ix;
    res = 64'h0000_0000_0000_0000;
    case (o)
      OP_ABS_W, OP_NRW_SRA_PH, OP_NRW_Q31_PH, OP_NRW_RS_PH, OP_NRW_Q63, OP_WID_Q15_W,
      OP_WID_Q31_L: n = 1;
      OP_ABS_QB, OP_ABS_QH, OP_NRW_INT_OB, OP_NRW_FRAC_OB, OP_NRW_UB_OB, OP_WID_UBQ_QH,
      OP_WID_UBH_QH: n = 4;
      OP_ABS_OB: n = 8;
      default: n = 2;
    endcase
    case (o)
      OP_ABS_QB, OP_ABS_OB, OP_WID_UBQ_PH, OP_WID_UBQ_QH, OP_WID_UBH_PH, OP_WID_UBH_QH: w = 8;
      OP_ABS_W, OP_ABS_PW, OP_NRW_SRA_PH, OP_NRW_SRA_QH, OP_NRW_Q31_PH, OP_NRW_Q31_QH,
      OP_NRW_RS_PH, OP_NRW_RS_QH, OP_WID_Q31_L: w = 32;
      OP_NRW_Q63: w = 64;
      default: w = 16;
    endcase
    case (o)
      OP_WID_Q15_W, OP_WID_Q15_PW: sh = 16;
      OP_WID_Q31_L: sh = 32;
      OP_WID_UBQ_PH, OP_WID_UBQ_QH: sh = 7;
      default: sh = 8;
    endcase
    m = (64'h0000_0000_0000_0001 << w) - 1;
    if (o == OP_CIRC_DEC)
      res[31:0] = (ra[31:0] < rb[7:0]) ? rb[23:8] : ra[31:0] - rb[7:0];
    for (int k = 0; k < 8; k++)
      if ((o == OP_SUM_W && k < 4) || o == OP_SUM_D) res += ra[8*k +: 8];
    if (o >= OP_ABS_QB && o <= OP_ABS_PW)
      for (int k = 0; k < n; k++)
        res |= sabs((rb >> (w * k)) & m, w) << (w * k);
    if (o >= OP_NRW_INT_QB && o <= OP_NRW_UB_OB)
      for (int q = 0; q < 2; q++)
        for (int k = 0; k < n; k++) begin
          e = ((q == 1 ? ra : rb) >> (w * k)) & m;
          res |= nar(o, e, sh_a, r) << ((w / 2) * (q * n + k));
        end
    if (o >= OP_WID_Q15_W && o <= OP_WID_UBH_QH)
      for (int k = 0; k < n; k++) begin
        case (s)
          SEL_LEFT: ix = n + k;
          SEL_RIGHT: ix = k;
          SEL_LEFT_ALT: ix = 2 * k + 1;
          default: ix = 2 * k;
        endcase
        res |= (((rb >> (w * ix)) & m) << sh) << (2 * w * k);
      end
    if (o inside {OP_CIRC_DEC, OP_SUM_W, OP_ABS_QB, OP_ABS_PH, OP_ABS_W, OP_NRW_INT_QB,
                  OP_NRW_FRAC_QB, OP_NRW_SRA_PH, OP_NRW_Q31_PH, OP_NRW_RS_PH, OP_NRW_UB_QB,
                  OP_WID_Q15_W, OP_WID_UBQ_PH, OP_WID_UBH_PH})
      res = {{32{res[31]}}, res[31:0]};
    return res;
  endfunction

  // note the expected result, then issue the op
  task automatic run(input spar_op_t o, input spar_sel_t s, input logic [63:0] ra,
                     input logic [63:0] rb, input logic [4:0] sh_a, input logic r);
    exp_q.push_back(ref_res(o, s, ra, rb, sh_a, r));
    spar_issue_model_inst.issue(o, s, ra, rb, sh_a, r);
  endtask

  // output watcher: oldest note against each result, hold check otherwise
  always @(posedge clk_in) begin
    logic [63:0] e;
    #1;
    if (rstn_in !== 1'b1) begin
      `CHK({rv, result}, 65'h0_0000_0000_0000_0000)
      last_q = 64'h0000_0000_0000_0000;
    end else if (rv === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 64'hxxxx_xxxx_xxxx_xxxx;
      `CHK(result, e)
      `CHK({gw, aw, sw}, 3'b100)
      last_q = result;
    end else begin
      `CHK(result, last_q)
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end

  // main sequence
  initial begin
    void'($urandom(42));
    repeat (6) @(negedge clk_in);
    rstn_in = 1'b1;
    run(OP_SUM_W, SEL_LEFT, 64'hffff_ffff_8080_8080, 64'h0, 5'h00, 1'b0);
    run(OP_SUM_D, SEL_LEFT, 64'h8080_8080_8080_8080, 64'h0, 5'h00, 1'b0);
    run(OP_SUM_D, SEL_LEFT, 64'hffff_ffff_ffff_ffff, 64'h0, 5'h00, 1'b0);
    run(OP_CIRC_DEC, SEL_LEFT, 64'h10, 64'h0012_3411, 5'h00, 1'b0);
    run(OP_CIRC_DEC, SEL_LEFT, 64'h10, 64'h00ab_cd10, 5'h00, 1'b0);
    run(OP_CIRC_DEC, SEL_LEFT, 64'hffff_ff00, 64'h0000_0001, 5'h00, 1'b0);
    spar_issue_model_inst.idle();
    spar_issue_model_inst.idle();
    for (int o = OP_ABS_QB; o <= OP_ABS_PW; o++) begin
      run(spar_op_t'(o), SEL_LEFT, 64'h0, 64'h8000_0000_8080_0180, 5'h00, 1'b0);
      run(spar_op_t'(o), SEL_LEFT, 64'h0, 64'h7f80_8000_8000_0000, 5'h00, 1'b0);
    end
    run(OP_NRW_RS_PH, SEL_LEFT, 64'h7fff_8000, 64'h7fff_7fff, 5'h00, 1'b0);
    run(OP_NRW_UB_QB, SEL_LEFT, 64'h7f80_7f81, 64'h8000_0100, 5'h00, 1'b0);
    run(OP_NRW_SRA_PH, SEL_LEFT, 64'h0001_8000, 64'hfff0_0000, 5'h10, 1'b1);
    spar_issue_model_inst.idle();
    // second reset in mid-run with nothing in flight
    @(negedge clk_in);
    rstn_in = 1'b0;
    repeat (2) @(negedge clk_in);
    rstn_in = 1'b1;
    // every code and selector, random operands, back to back with random bubbles
    for (int rep = 0; rep < 8; rep++)
      for (int o = 0; o < 32; o++)
        for (int s = 0; s < 4; s++) begin
          run(spar_op_t'(o), spar_sel_t'(s), {$urandom, $urandom}, {$urandom, $urandom},
              5'($urandom), 1'($urandom));
          if ($urandom % 8 == 0) spar_issue_model_inst.idle();
        end
    repeat (3) spar_issue_model_inst.idle();
    `CHK(exp_q.size(), 0)
    report_and_stop();
  end
endmodule

// ---- spar_issue_model.sv ----
`timescale 1ns/1ps
// core pipeline issue side: one decoded op per cycle, driven off the falling edge
module spar_issue_model
  import spar_pkg::*;
(
  input  wire logic        clk_in,
  output logic             valid_out,
  output spar_op_t         op_out,
  output spar_sel_t        select_out,
  output logic [63:0]      reg_a_out,
  output logic [63:0]      reg_b_out,
  output logic [4:0]       shift_out,
  output logic             round_out
);
  // idle values from time zero
  initial begin
    valid_out = 1'b0;
    op_out = OP_CIRC_DEC;
    select_out = SEL_LEFT;
    reg_a_out = 64'h0000_0000_0000_0000;
    reg_b_out = 64'h0000_0000_0000_0000;
    shift_out = 5'h00;
    round_out = 1'b0;
  end

  // issue one op; valid stays high so calls in a row run back to back
  task automatic issue(input spar_op_t op, input spar_sel_t sel, input logic [63:0] a,
                       input logic [63:0] b, input logic [4:0] sa, input logic rnd);
    @(negedge clk_in);
    op_out = op;
    select_out = sel;
    reg_a_out = a;
    reg_b_out = b;
    shift_out = sa;
    round_out = rnd;
    valid_out = 1'b1;
  endtask

  // bubble; operands are scrambled since the block must ignore them
  task automatic idle();
    @(negedge clk_in);
    valid_out = 1'b0;
    reg_a_out = ~reg_a_out;
    reg_b_out = {reg_b_out[31:0], ~reg_b_out[63:32]};
  endtask
endmodule

// ---- spar_pkg.sv ----
package spar_pkg;

  // element and register widths
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned DWORD_W = 64;
  localparam int unsigned SHIFT_W = 5;

  // circular index fields inside source_reg_b
  localparam int unsigned DEC_LSB = 0;
  localparam int unsigned RESTART_LSB = 8;
  localparam int unsigned RESTART_W = 16;

  // saturation and rounding constants
  localparam logic [15:0] Q15_USAT_LIMIT = 16'h7f80;
  localparam logic [7:0] UBYTE_MAX = 8'hff;
  localparam logic [7:0] UBYTE_ZERO = 8'h00;
  localparam logic [31:0] Q31_RND_LIMIT = 32'h7fff_8000;
  localparam logic [31:0] Q31_RND_ADD = 32'h0000_8000;
  localparam logic [15:0] Q15_MAX = 16'h7fff;
  localparam logic [63:0] RESULT_RST = 64'h0000_0000_0000_0000;

  // operation selector
  typedef enum logic [4:0] {
    OP_CIRC_DEC      = 5'b00000,
    OP_SUM_W         = 5'b00001,
    OP_SUM_D         = 5'b00010,
    OP_ABS_QB        = 5'b00011,
    OP_ABS_OB        = 5'b00100,
    OP_ABS_PH        = 5'b00101,
    OP_ABS_QH        = 5'b00110,
    OP_ABS_W         = 5'b00111,
    OP_ABS_PW        = 5'b01000,
    OP_NRW_INT_QB    = 5'b01001,
    OP_NRW_INT_OB    = 5'b01010,
    OP_NRW_FRAC_QB   = 5'b01011,
    OP_NRW_FRAC_OB   = 5'b01100,
    OP_NRW_SRA_PH    = 5'b01101,
    OP_NRW_SRA_QH    = 5'b01110,
    OP_NRW_Q31_PH    = 5'b01111,
    OP_NRW_Q31_QH    = 5'b10000,
    OP_NRW_RS_PH     = 5'b10001,
    OP_NRW_RS_QH     = 5'b10010,
    OP_NRW_Q63       = 5'b10011,
    OP_NRW_UB_QB     = 5'b10100,
    OP_NRW_UB_OB     = 5'b10101,
    OP_WID_Q15_W     = 5'b10110,
    OP_WID_Q15_PW    = 5'b10111,
    OP_WID_Q31_L     = 5'b11000,
    OP_WID_UBQ_PH    = 5'b11001,
    OP_WID_UBQ_QH    = 5'b11010,
    OP_WID_UBH_PH    = 5'b11011,
    OP_WID_UBH_QH    = 5'b11100
  } spar_op_t;

  // element selector for widening ops
  typedef enum logic [1:0] {
    SEL_LEFT      = 2'b00,
    SEL_RIGHT     = 2'b01,
    SEL_LEFT_ALT  = 2'b10,
    SEL_RIGHT_ALT = 2'b11
  } spar_sel_t;

endpackage

// ---- spar_vec_if.sv ----
`timescale 1ns/1ps
// carries one packed vector to an abs lane and its magnitudes back
interface spar_vec_if;
  logic [63:0] vec;
  logic [63:0] mag;
  modport drv  (output vec, input mag);
  modport lane (input vec, output mag);
endinterface
